// ---- verilog/odsl_top.sv ----
// octal converter serial loader: link capture, frame control and channel outputs
`timescale 1ns/1ps
module odsl_top
(
   input  wire logic                                         CLK_SYS_IN,
   input  wire logic                                         RST_IN,
   input  wire logic                                         LINK_CLK_IN,
   input  wire logic                                         LINK_CS_N_IN,
   input  wire logic                                         SERIAL_IN,
   input  wire logic                                         MIDSCALE_PRESET_N_IN,
   input  wire logic                                         POWER_DOWN_N_IN,
   output logic [odsl_pkg::ODSL_CHAN_N*odsl_pkg::ODSL_VALUE_W-1:0] CHAN_VALUE_OUT,
   output logic [odsl_pkg::ODSL_CHAN_N-1:0]                 CHAN_OPEN_OUT,
   output logic [odsl_pkg::ODSL_CHAN_N-1:0]                 CHAN_UPDATE_OUT,
   output logic [odsl_pkg::ODSL_CHAN_N-1:0]                 CHAN_PROGRAMMED_OUT,
   output logic [odsl_pkg::ODSL_WORD_W-1:0]                 LAST_WORD_OUT,
   output logic [odsl_pkg::ODSL_ADDR_W-1:0]                 LAST_ADDR_OUT,
   output logic                                             SHUTDOWN_OUT,
   output logic                                             PRESET_OUT,
   output logic                                             BUSY_OUT
);
   import odsl_pkg::*;

   // ******************************************
   // internal signals
   // ******************************************
   odsl_core_if core ();

   // pin synchronisers and the select edges taken from them
   logic [ODSL_SYNC_N-1:0] sync_meta;
   logic [ODSL_SYNC_N-1:0] sync_level;
   logic [ODSL_SYNC_N-1:0] pins_async;
   logic                   cs_n_sync;
   logic                   cs_n_prev;
   logic                   cs_rise;
   logic                   cs_fall;
   logic                   preset_active;
   logic                   shutdown_active;

   // frame control, captured word and decode
   odsl_frame_t            frame_state;
   odsl_frame_t            next_frame_state;
   odsl_word_t             captured_word;
   logic                   word_valid;
   odsl_addr_t             decode_addr;
   odsl_value_t            decode_value;
   odsl_mask_t             decode_onehot;

   // status registers that stand behind the outputs
   odsl_mask_t             programmed;
   odsl_mask_t             update_pulse;
   odsl_mask_t             open_mask;
   odsl_word_t             last_word;
   odsl_addr_t             last_addr;
   logic                   shutdown_flag;
   logic                   preset_flag;
   logic                   busy_flag;

   // ******************************************
   // link side: serial register on the host clock
   // ******************************************
   // the three host inputs: clock and data feed the shifter directly
   odsl_link_shift u_shift
   (
      .link_clk_in (LINK_CLK_IN),
      .rst_in      (RST_IN),
      .cs_n_in     (LINK_CS_N_IN),
      .serial_in   (SERIAL_IN),
      .core        (core.shifter)
   );

   // ******************************************
   // synchronisers for pins read in the system domain
   // ******************************************
   // select, preset and shutdown all arrive with no relation to the system clock
   assign pins_async[ODSL_SYNC_CS]     = LINK_CS_N_IN;
   assign pins_async[ODSL_SYNC_PRESET] = MIDSCALE_PRESET_N_IN;
   assign pins_async[ODSL_SYNC_PDOWN]  = POWER_DOWN_N_IN;

   // two stages per pin; only the second stage is looked at by any logic
   generate
      for (genvar s = 0; s < ODSL_SYNC_N; s++)
      begin : g_sync
         always_ff @(posedge CLK_SYS_IN or posedge RST_IN)
         begin
            if (RST_IN)
            begin
               sync_meta[s]  <= ODSL_SYNC_RESET[s];
               sync_level[s] <= ODSL_SYNC_RESET[s];
            end
            else
            begin
               sync_meta[s]  <= pins_async[s];
               sync_level[s] <= sync_meta[s];
            end
         end
      end
   endgenerate

   // active-low preset and shutdown pins turned into active-high conditions; select stays active-low
   assign cs_n_sync       = sync_level[ODSL_SYNC_CS];
   assign preset_active   = !sync_level[ODSL_SYNC_PRESET];
   assign shutdown_active = !sync_level[ODSL_SYNC_PDOWN];

   // ******************************************
   // select edge detection
   // ******************************************
   // previous level starts high so a reset never fakes a rising edge
   always_ff @(posedge CLK_SYS_IN or posedge RST_IN)
   begin
      if (RST_IN)
         cs_n_prev <= 1'b1;
      else
         cs_n_prev <= cs_n_sync;
   end

   // a fall opens a frame and the following rise closes it
   assign cs_rise = cs_n_sync && !cs_n_prev;
   assign cs_fall = !cs_n_sync && cs_n_prev;

   // ******************************************
   // frame state machine
   // ******************************************
   // a rise seen while idle is impossible; the machine needs a fall first
   always_comb
   begin
      next_frame_state = frame_state;
      unique case (frame_state)
         FR_IDLE:
         begin
            if (cs_fall)
               next_frame_state = FR_ACTIVE;
         end
         FR_ACTIVE:
         begin
            // clock edges meanwhile are the shifter's business, not ours
            if (cs_rise)
               next_frame_state = FR_LATCH;
         end
         FR_LATCH:
         begin
            // a quick new frame may already have pulled select low again
            if (!cs_n_sync)
               next_frame_state = FR_ACTIVE;
            else
               next_frame_state = FR_IDLE;
         end
         // the fourth code of the state register is never entered
         default:
            next_frame_state = FR_IDLE;
      endcase
   end

   always_ff @(posedge CLK_SYS_IN or posedge RST_IN)
   begin
      if (RST_IN)
         frame_state <= FR_IDLE;
      else
         frame_state <= next_frame_state;
   end

   // ******************************************
   // word capture across the clock boundary
   // ******************************************
   // the serial word is quasi static here: the host holds the clock high as
   // select rises, so no link edge moves it until the next frame shifts;
   // a select-high time shorter than three system cycles would be a hazard;
   // limitation: nothing checks that the host really parked its clock high
   always_ff @(posedge CLK_SYS_IN or posedge RST_IN)
   begin
      if (RST_IN)
         captured_word <= ODSL_WORD_RESET;
      else if ((frame_state == FR_ACTIVE) && cs_rise)
         captured_word <= core.word;
   end

   // word_valid is high in exactly the cycle the load strobe fires
   assign word_valid = (frame_state == FR_LATCH);

   // ******************************************
   // address decode and load strobe
   // ******************************************
   // top three bits address, bottom eight carry the value
   assign decode_addr  = captured_word[ODSL_ADDR_MSB:ODSL_ADDR_LSB];
   assign decode_value = captured_word[ODSL_VALUE_MSB:ODSL_VALUE_LSB];

   // channel number seen outside is address plus one; index zero is channel one
   always_comb
   begin
      decode_onehot = ODSL_MASK_RESET;
      if (word_valid)
         decode_onehot[decode_addr] = 1'b1;
   end

   // the bank sees strobe, address and value together in the latch cycle
   assign core.load       = word_valid;
   assign core.load_addr  = decode_addr;
   assign core.load_value = decode_value;
   assign core.preset     = preset_active;

   // ******************************************
   // channel registers
   // ******************************************
   // preset outranks a load inside the bank, so no load can undo it
   odsl_chan_bank u_bank
   (
      .clk_in (CLK_SYS_IN),
      .rst_in (RST_IN),
      .core   (core.bank)
   );

   // ******************************************
   // update reporting
   // ******************************************
   // a load swallowed by preset is not reported, matching what the bank kept
   always_ff @(posedge CLK_SYS_IN or posedge RST_IN)
   begin
      if (RST_IN)
         update_pulse <= ODSL_MASK_RESET;
      else if (preset_active)
         update_pulse <= ODSL_MASK_RESET;
      else
         update_pulse <= decode_onehot;
   end

   // programmed mask: cleared by preset, since every channel is midscale again
   always_ff @(posedge CLK_SYS_IN or posedge RST_IN)
   begin
      if (RST_IN)
         programmed <= ODSL_MASK_RESET;
      else if (preset_active)
         programmed <= ODSL_MASK_RESET;
      else
         programmed <= programmed | decode_onehot;
   end

   // last command word and address kept for inspection;
   // only a latch cycle moves them, so they show the newest command until the next
   always_ff @(posedge CLK_SYS_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         last_word <= ODSL_WORD_RESET;
         last_addr <= ODSL_ADDR_RESET;
      end
      else if (word_valid)
      begin
         last_word <= captured_word;
         last_addr <= decode_addr;
      end
   end

   // ******************************************
   // shutdown and status
   // ******************************************
   // shutdown only opens the outputs; the values behind them stay untouched;
   // limitation: the open state follows the pin two to three system cycles late
   always_ff @(posedge CLK_SYS_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         open_mask     <= ODSL_MASK_RESET;
         shutdown_flag <= 1'b0;
      end
      else
      begin
         open_mask     <= {ODSL_CHAN_N{shutdown_active}};
         shutdown_flag <= shutdown_active;
      end
   end

   // preset and busy status, registered like every other data output
   always_ff @(posedge CLK_SYS_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         preset_flag <= 1'b0;
         busy_flag   <= 1'b0;
      end
      else
      begin
         preset_flag <= preset_active;
         // looking one state ahead lets busy rise at the same edge as the move to FR_ACTIVE, one cycle after the fall is seen
         busy_flag   <= (next_frame_state != FR_IDLE);
      end
   end

   // ******************************************
   // outputs
   // ******************************************
   // every output below comes straight from a flip-flop
   assign CHAN_VALUE_OUT      = core.values;
   assign CHAN_OPEN_OUT       = open_mask;
   assign CHAN_UPDATE_OUT     = update_pulse;
   assign CHAN_PROGRAMMED_OUT = programmed;
   assign LAST_WORD_OUT       = last_word;
   assign LAST_ADDR_OUT       = last_addr;
   assign SHUTDOWN_OUT        = shutdown_flag;
   assign PRESET_OUT          = preset_flag;
   assign BUSY_OUT            = busy_flag;

endmodule

// ---- pkg/odsl_pkg.sv ----
// constants, types and states shared by the octal converter serial loader
package odsl_pkg;

   // ******************************************
   // word layout
   // ******************************************
   localparam int ODSL_ADDR_W    = 3;
   localparam int ODSL_VALUE_W   = 8;
   localparam int ODSL_WORD_W    = ODSL_ADDR_W + ODSL_VALUE_W;
   localparam int ODSL_CHAN_N    = 8;
   localparam int ODSL_VALUE_LSB = 0;
   localparam int ODSL_VALUE_MSB = ODSL_VALUE_W - 1;
   localparam int ODSL_ADDR_LSB  = ODSL_VALUE_W;
   localparam int ODSL_ADDR_MSB  = ODSL_WORD_W - 1;
   localparam int ODSL_CHAN_BASE = 1;

   // ******************************************
   // reset values and synchroniser layout
   // ******************************************
   localparam int         ODSL_SYNC_N      = 3;
   localparam int         ODSL_SYNC_CS     = 0;
   localparam int         ODSL_SYNC_PRESET = 1;
   localparam int         ODSL_SYNC_PDOWN  = 2;
   localparam logic [2:0] ODSL_SYNC_RESET  = 3'h7;
   localparam logic [7:0] ODSL_MIDSCALE    = 8'h80;
   localparam logic [7:0] ODSL_MASK_RESET  = 8'h00;
   localparam logic [2:0] ODSL_ADDR_RESET  = 3'h0;
   localparam logic [10:0] ODSL_WORD_RESET = 11'h000;

   // ******************************************
   // types
   // ******************************************
   typedef logic [ODSL_VALUE_W-1:0] odsl_value_t;
   typedef logic [ODSL_ADDR_W-1:0]  odsl_addr_t;
   typedef logic [ODSL_WORD_W-1:0]  odsl_word_t;
   typedef logic [ODSL_CHAN_N-1:0]  odsl_mask_t;

   typedef enum logic [1:0] {
      FR_IDLE,
      FR_ACTIVE,
      FR_LATCH
   } odsl_frame_t;

endpackage

// ---- pkg/odsl_core_if.sv ----
// signals joining the link shifter, the frame controller and the channel bank
`timescale 1ns/1ps
interface odsl_core_if;
   import odsl_pkg::*;

   odsl_word_t                     word;
   logic                           load;
   odsl_addr_t                     load_addr;
   odsl_value_t                    load_value;
   logic                           preset;
   logic [ODSL_CHAN_N*ODSL_VALUE_W-1:0] values;

   modport shifter (output word);
   modport ctrl    (input word, input values, output load, output load_addr, output load_value, output preset);
   modport bank    (input load, input load_addr, input load_value, input preset, output values);
endinterface

// ---- verilog/odsl_link_shift.sv ----
// serial input register running on the host's shift clock
`timescale 1ns/1ps
module odsl_link_shift
(
   input  wire logic                 link_clk_in,
   input  wire logic                 rst_in,
   input  wire logic                 cs_n_in,
   input  wire logic                 serial_in,
   odsl_core_if.shifter              core
);
   import odsl_pkg::*;

   odsl_word_t shift;

   // ******************************************
   // shift register
   // ******************************************
   // only the low eleven positions exist, so older bits fall off the top
   always_ff @(posedge link_clk_in or posedge rst_in)
   begin
      if (rst_in)
         shift <= ODSL_WORD_RESET;
      else if (!cs_n_in)
         shift <= {shift[ODSL_WORD_W-2:0], serial_in};
   end

   // held steady after select rises because no edge is accepted then
   assign core.word = shift;

endmodule

// ---- verilog/odsl_chan_bank.sv ----
// eight channel value registers with preset and single-channel load
`timescale 1ns/1ps
module odsl_chan_bank
(
   input  wire logic                 clk_in,
   input  wire logic                 rst_in,
   odsl_core_if.bank                 core
);
   import odsl_pkg::*;

   odsl_value_t chan_value [ODSL_CHAN_N];

   // ******************************************
   // channel registers
   // ******************************************
   // preset outranks a load landing in the same cycle; shutdown has no say here
   generate
      for (genvar i = 0; i < ODSL_CHAN_N; i++)
      begin : g_chan
         always_ff @(posedge clk_in or posedge rst_in)
         begin
            if (rst_in)
               chan_value[i] <= ODSL_MIDSCALE;
            else if (core.preset)
               chan_value[i] <= ODSL_MIDSCALE;
            else if (core.load && (core.load_addr == ODSL_ADDR_W'(i)))
               chan_value[i] <= core.load_value;
         end

         assign core.values[i*ODSL_VALUE_W +: ODSL_VALUE_W] = chan_value[i];
      end
   endgenerate

endmodule

// ---- testbench/odsl_props.sv ----
// concurrent checks on the loader's top-level ports
`timescale 1ns/1ps
module odsl_props
(
   input wire logic        CLK_SYS_IN,
   input wire logic        RST_IN,
   input wire logic        LINK_CLK_IN,
   input wire logic        LINK_CS_N_IN,
   input wire logic        SERIAL_IN,
   input wire logic        MIDSCALE_PRESET_N_IN,
   input wire logic        POWER_DOWN_N_IN,
   input wire logic [63:0] CHAN_VALUE_OUT,
   input wire logic [7:0]  CHAN_OPEN_OUT,
   input wire logic [7:0]  CHAN_UPDATE_OUT,
   input wire logic [7:0]  CHAN_PROGRAMMED_OUT,
   input wire logic [10:0] LAST_WORD_OUT,
   input wire logic [2:0]  LAST_ADDR_OUT,
   input wire logic        SHUTDOWN_OUT,
   input wire logic        PRESET_OUT,
   input wire logic        BUSY_OUT
);
   import odsl_pkg::*;
   default clocking cb @(posedge CLK_SYS_IN);
   endclocking
   default disable iff (RST_IN);

   // ******************************************
   // frame end to channel load
   // ******************************************
   // preset must be idle, since a load under preset is dropped
   sequence s_cs_rise;
      $rose(LINK_CS_N_IN) && MIDSCALE_PRESET_N_IN && !PRESET_OUT;
   endsequence
   sequence s_load;
      ##[3:5] (CHAN_UPDATE_OUT != 8'h00);
   endsequence
   property p_load;
      s_cs_rise |-> s_load;
   endproperty
   a_load: assert property (p_load) else $error("no load after select rise");
   property p_onehot;
      (CHAN_UPDATE_OUT != 8'h00) |-> $onehot(CHAN_UPDATE_OUT) ##1 (CHAN_UPDATE_OUT == 8'h00);
   endproperty
   a_onehot: assert property (p_onehot) else $error("update not a single one-hot pulse");
   property p_addr;
      (CHAN_UPDATE_OUT != 8'h00) |-> CHAN_UPDATE_OUT == (8'h01 << LAST_ADDR_OUT)
         && LAST_ADDR_OUT == LAST_WORD_OUT[10:8];
   endproperty
   a_addr: assert property (p_addr) else $error("wrong channel for address");
   property p_value;
      (CHAN_UPDATE_OUT != 8'h00) |-> CHAN_VALUE_OUT[{LAST_ADDR_OUT, 3'h0} +: 8] == LAST_WORD_OUT[7:0];
   endproperty
   a_value: assert property (p_value) else $error("channel value not low byte of word");
   property p_prog;
      (CHAN_UPDATE_OUT != 8'h00) |=> (CHAN_PROGRAMMED_OUT & $past(CHAN_UPDATE_OUT)) != 8'h00;
   endproperty
   a_prog: assert property (p_prog) else $error("loaded channel not marked");

   // ******************************************
   // holding, preset and shutdown
   // ******************************************
   // a value may move only by a load or by the preset
   property p_hold;
      $changed(CHAN_VALUE_OUT) |-> (CHAN_UPDATE_OUT != 8'h00) or ##1 PRESET_OUT;
   endproperty
   a_hold: assert property (p_hold) else $error("channel value moved without cause");
   property p_preset;
      PRESET_OUT |-> CHAN_VALUE_OUT == {8{ODSL_MIDSCALE}} && CHAN_PROGRAMMED_OUT == 8'h00;
   endproperty
   a_preset: assert property (p_preset) else $error("preset did not force midscale");
   property p_open;
      $stable(SHUTDOWN_OUT) |-> CHAN_OPEN_OUT == {8{SHUTDOWN_OUT}};
   endproperty
   a_open: assert property (p_open) else $error("open state disagrees with shutdown");
endmodule

bind odsl_top odsl_props u_odsl_props
(
   .CLK_SYS_IN, .RST_IN, .LINK_CLK_IN, .LINK_CS_N_IN, .SERIAL_IN, .MIDSCALE_PRESET_N_IN,
   .POWER_DOWN_N_IN, .CHAN_VALUE_OUT, .CHAN_OPEN_OUT, .CHAN_UPDATE_OUT, .CHAN_PROGRAMMED_OUT,
   .LAST_WORD_OUT, .LAST_ADDR_OUT, .SHUTDOWN_OUT, .PRESET_OUT, .BUSY_OUT
);

// ---- testbench/odsl_host_model.sv ----
// host model driving the three-wire link: select, shift clock and data
`timescale 1ns/1ps
module odsl_host_model
(
   output logic link_clk_out,
   output logic cs_n_out,
   output logic serial_out
);
   import odsl_pkg::*;
   // idle: clock parked high, select high; only these three lines reach the device
   initial
   begin
      link_clk_out = 1'b1;
      cs_n_out     = 1'b1;
      serial_out   = 1'b0;
   end
   // data moves on the falling edge so it is steady at the rising one
   task automatic shift_bit(input logic b);
      link_clk_out = 1'b0;
      serial_out   = b;
      #40;
      link_clk_out = 1'b1;
      #40;
   endtask
   task automatic frame(input logic [15:0] w, input int n);
      #7;
      cs_n_out = 1'b0; // select falls to open the transfer
      #40;
      for (int i = n - 1; i >= 0; i--)
         shift_bit(w[i]); // most significant bit first
      cs_n_out   = 1'b1; // clock is high as select rises
      serial_out = ~serial_out; // released line must not look valid
   endtask
   task automatic send11(input odsl_word_t w);
      frame(16'(w), 11);
   endtask
   task automatic send16(input logic [15:0] w);
      frame(w, 16);
   endtask
   // clock with select high; data toggles so a stray shift would show
   task automatic idle_clocks(input int n);
      repeat (n)
      begin
         link_clk_out = 1'b0;
         serial_out   = ~serial_out;
         #40;
         link_clk_out = 1'b1;
         #40;
      end
   endtask
endmodule

// ---- testbench/odsl_top_tb.sv ----
// self-checking bench for the octal converter serial loader
`timescale 1ns/1ps
module odsl_top_tb;
   import odsl_pkg::*;
   logic        clk_sys  = 1'b0;
   logic        rst      = 1'b1;
   logic        preset_n = 1'b1;
   logic        pdown_n  = 1'b1;
   wire logic   link_clk;
   wire logic   cs_n;
   wire logic   sdata;
   logic [63:0] vals;
   logic [63:0] exp_v;
   logic [7:0]  open_m;
   logic [7:0]  upd;
   logic [7:0]  prog;
   logic [10:0] lword;
   logic [2:0]  laddr;
   logic        sd;
   logic        pre;
   logic        busy;
   int          error_cnt  = 0;
   int          n_compared = 0;
   int          cyc        = 0;

   always #5 clk_sys = ~clk_sys;

   odsl_top u_odsl_top (.CLK_SYS_IN(clk_sys), .RST_IN(rst), .LINK_CLK_IN(link_clk), .LINK_CS_N_IN(cs_n),
      .SERIAL_IN(sdata), .MIDSCALE_PRESET_N_IN(preset_n), .POWER_DOWN_N_IN(pdown_n), .CHAN_VALUE_OUT(vals),
      .CHAN_OPEN_OUT(open_m), .CHAN_UPDATE_OUT(upd), .CHAN_PROGRAMMED_OUT(prog), .LAST_WORD_OUT(lword),
      .LAST_ADDR_OUT(laddr), .SHUTDOWN_OUT(sd), .PRESET_OUT(pre), .BUSY_OUT(busy));
   odsl_host_model u_odsl_host_model (.link_clk_out(link_clk), .cs_n_out(cs_n), .serial_out(sdata));

   // ******************************************
   // shared tasks
   // ******************************************
   task automatic print_verdict;
      $display("compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // also keeps select high long enough before the next frame
   task automatic wait_upd(output logic [7:0] m);
      m = 8'h00;
      repeat (12)
      begin
         @(posedge clk_sys);
         #1;
         if (upd !== 8'h00 && m === 8'h00)
            m = upd;
      end
   endtask
   task automatic load(input odsl_word_t w, input logic [7:0] exp_m);
      logic [7:0] m;
      u_odsl_host_model.send11(w);
      chk(64'(busy), 64'h1); // frame still open as select rises
      wait_upd(m);
      chk(64'(m), 64'(exp_m)); // update mask matches exp_m: one channel, or none under preset
      chk(64'(busy), 64'h0); // frame closed after the latch
   endtask
   task automatic settle;
      repeat (6) @(posedge clk_sys);
      #1;
   endtask

   // ******************************************
   // scenarios
   // ******************************************
   task automatic t_reset;
      chk(vals, {8{ODSL_MIDSCALE}});
      chk(64'({open_m, upd, prog, lword, laddr, sd, pre, busy}), 64'h0); // outputs quiet after reset
   endtask
   task automatic t_each_chan;
      for (int a = 0; a < ODSL_CHAN_N; a++)
      begin
         exp_v[a*8 +: 8] = 8'(8'hC3 ^ (a * 8'h29));
         load({a[2:0], exp_v[a*8 +: 8]}, 8'(8'h01 << a));
         chk(vals, exp_v);
         chk(64'(lword), 64'({a[2:0], exp_v[a*8 +: 8]}));
         chk(64'(laddr), 64'(a[2:0]));
      end
      chk(64'(prog), 64'hFF);
   endtask
   // first eleven bits would name channel eight, last eleven name six
   task automatic t_long;
      logic [7:0] m;
      u_odsl_host_model.send16(16'hFD3E);
      wait_upd(m);
      exp_v[40 +: 8] = 8'h3E;
      chk(64'(m), 64'h20);
      chk(vals, exp_v);
   endtask
   task automatic t_idle;
      logic [7:0] m;
      u_odsl_host_model.idle_clocks(8);
      wait_upd(m);
      chk(64'(m), 64'h0);
      chk(vals, exp_v);
      // eight bits only: the address comes from the tail of the long frame's word
      u_odsl_host_model.frame(16'h00A5, 8);
      wait_upd(m);
      exp_v[48 +: 8] = 8'hA5;
      chk(64'(m), 64'h40); // a stray idle shift would move the address
      chk(vals, exp_v);
   endtask
   task automatic t_shutdown;
      @(posedge clk_sys) pdown_n <= 1'b0;
      settle();
      chk(64'({sd, open_m}), 64'h1FF);
      chk(vals, exp_v); // values kept on entry
      exp_v[16 +: 8] = 8'h00;
      load({3'h2, 8'h00}, 8'h04); // loads still land in shutdown
      chk(vals, exp_v);
      @(posedge clk_sys) pdown_n <= 1'b1;
      settle();
      chk(64'({sd, open_m}), 64'h0);
      chk(vals, exp_v);
   endtask
   task automatic t_preset;
      @(posedge clk_sys) preset_n <= 1'b0;
      settle();
      chk(64'({pre, prog}), 64'h100);
      load({3'h7, 8'hFF}, 8'h00); // preset wins over a load
      chk(vals, {8{ODSL_MIDSCALE}});
      @(posedge clk_sys) preset_n <= 1'b1;
      settle();
      exp_v = {8{ODSL_MIDSCALE}};
      exp_v[56 +: 8] = 8'hFF;
      load({3'h7, 8'hFF}, 8'h80);
      chk(vals, exp_v);
   endtask

   // ******************************************
   // sequence and timeout
   // ******************************************
   initial
   begin
      exp_v = {8{ODSL_MIDSCALE}};
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      settle();
      t_reset();
      t_each_chan();
      t_long();
      t_idle();
      t_shutdown();
      t_preset();
      print_verdict();
   end
   // the whole run needs about fifteen hundred cycles
   always @(posedge clk_sys)
   begin
      cyc <= cyc + 1;
      if (cyc == 10000)
      begin
         error_cnt++;
         print_verdict();
      end
   end
endmodule
